// file: dv/dac_serial_load_power_control_test.sv
// self-checking bench: narrow and wide variants share one host link
// assumes wake_count shortened to 20 clk
`timescale 1ns/1ns
module dac_serial_load_power_control_test;
   import dac_load_pkg::*;
   logic clk, rst, frame_sel_n, serial_clk, serial_din;
   logic [15:0] code_n, code_w;
   power_mode_t mode_n, mode_w;
   logic [3:0] pin_n, pin_w;
   logic ex_n, ex_w;
   int error_cnt = 0, checks = 0, seed = 32'hd2bb;
   int n_code = 0, n_mode = 0, w_code = 0, w_mode = 0;
   int exn = 0, exw = 0, e_exn = 0, e_exw = 0;
   dac_serial_load_power_control #(.wide_variant(1'b0), .wake_count(20))
   u_dac_serial_load_power_control_narrow (.clk(clk), .rst(rst),
      .frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
      .serial_din(serial_din), .dac_code(code_n), .power_mode(mode_n),
      .amp_enable(pin_n[3]), .term_1k_en(pin_n[2]),
      .term_100k_en(pin_n[1]), .output_valid(pin_n[0]), .exec_pulse(ex_n));
   dac_serial_load_power_control #(.wide_variant(1'b1), .wake_count(20))
   u_dac_serial_load_power_control_wide (.clk(clk), .rst(rst),
      .frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
      .serial_din(serial_din), .dac_code(code_w), .power_mode(mode_w),
      .amp_enable(pin_w[3]), .term_1k_en(pin_w[2]),
      .term_100k_en(pin_w[1]), .output_valid(pin_w[0]), .exec_pulse(ex_w));
   serial_host_model u_serial_host_model (.frame_sel_n(frame_sel_n),
      .serial_clk(serial_clk), .serial_din(serial_din));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   int wk_n = 1000, wk_w = 1000;
   always @(posedge clk) begin
      if (ex_n === 1'b1) exn++;
      if (ex_w === 1'b1) exw++;
   end
   // cycles since mode returned to normal; valid must follow the wake delay
   always @(posedge clk) begin
      if (rst) begin
         wk_n = 1000;
         wk_w = 1000;
      end else begin
         wk_n = (mode_n !== pm_normal) ? 0 : (wk_n < 1000 ? wk_n + 1 : wk_n);
         wk_w = (mode_w !== pm_normal) ? 0 : (wk_w < 1000 ? wk_w + 1 : wk_w);
         if (pin_n[0] === 1'b1 ? wk_n < 15 : wk_n > 25)
            bad("narrow valid off wake delay");
         if (pin_w[0] === 1'b1 ? wk_w < 15 : wk_w > 25)
            bad("wide valid off wake delay");
      end
   end
   task automatic bad(input string s);
      error_cnt++;
      $display("ERROR at %0t: %s", $time, s);
   endtask
   task automatic cmp(input logic [15:0] c, input logic [1:0] m,
         input logic [3:0] p, input int ec, input int em, input int ex,
         input int eex);
      checks++;
      if (c !== 16'(ec) || m !== 2'(em) || ex != eex ||
            p !== {em == 0, em == 1, em == 2, em == 0})
         bad($sformatf("got %h %h %b want %h %0d", c, m, p, ec, em));
   endtask
   task automatic frame(input int md, input int cd, input int n);
      @(negedge clk);
      u_serial_host_model.send({md[1:0], cd[15:0], 6'($random(seed))}, n);
      if (n >= narrow_exec_edge) begin
         n_mode = md;
         n_code = cd >> 2;
         e_exn++;
      end
      if (n >= wide_exec_edge) begin
         w_mode = md;
         w_code = cd;
         e_exw++;
      end
      repeat (40) @(negedge clk);
      cmp(code_n, mode_n, pin_n, n_code, n_mode, exn, e_exn);
      cmp(code_w, mode_w, pin_w, w_code, w_mode, exw, e_exw);
      $display("frame mode %0d edges %0d done", md, n);
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #300000;
      bad("timeout");
      wrap_up;
   end
   initial begin
      rst = 1'b1;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (5) @(negedge clk);
      cmp(code_n, mode_n, pin_n, 0, 0, exn, 0);
      cmp(code_w, mode_w, pin_w, 0, 0, exw, 0);
      frame(0, 16'hffff, 24);
      frame(0, 0, 24);
      frame(0, $random(seed) & 16'hffff, 24);
      for (int md = 1; md < 4; md++) begin
         frame(md, w_code, 24);
         frame(0, $random(seed) & 16'hffff, 24);
      end
      frame(3, 16'h5a5a, 10);
      frame(0, $random(seed) & 16'hffff, 18);
      frame(2, $random(seed) & 16'hffff, 17);
      for (int k = 0; k < 4; k++) begin
         frame(0, $random(seed) & 16'hffff, 24);
      end
      wrap_up;
   end
endmodule

// file: dv/serial_host_model.sv
// host serial master: select, serial clock and data for write frames
// assumes frames are started on a falling edge of the system clock
`timescale 1ns/1ns
module serial_host_model (
   // serial link pins
   output logic frame_sel_n,
   output logic serial_clk,
   output logic serial_din
);
   initial begin
      frame_sel_n = 1'b1;
      serial_clk = 1'b1;
      serial_din = 1'b0;
   end
   // clock idles high and stands still between frames
   task automatic send(input logic [23:0] bits, input int n);
      frame_sel_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         serial_din = bits[23-i];
         #40 serial_clk = 1'b0;
         #40 serial_clk = 1'b1;
      end
      frame_sel_n = 1'b1;
      // released data line must not keep a stale value
      serial_din = ~serial_din;
      #120;
   endtask
endmodule

// file: rtl/dac_load_pkg.sv
// constants and types for the serial-load front end of a string converter
// assumes one 100 MHz system clock; serial pins are asynchronous to it
package dac_load_pkg;
   localparam int unsigned clk_mhz = 100;
   localparam int unsigned wake_time_us = 50;
   localparam int unsigned wake_cycles = wake_time_us * clk_mhz;
   localparam int unsigned narrow_code_w = 14;
   localparam int unsigned wide_code_w = 16;
   localparam int unsigned narrow_frame_bits = 16;
   localparam int unsigned wide_frame_bits = 24;
   localparam int unsigned narrow_exec_edge = 16;
   localparam int unsigned wide_exec_edge = 18;
   localparam int unsigned mode_hi_pos = 1;
   localparam int unsigned mode_lo_pos = 0;
   localparam logic [1:0] mode_reset = 2'h0;
   localparam int unsigned code_reset = 0;
   typedef enum logic [1:0] {
      pm_normal = 2'h0,
      pm_1k_gnd = 2'h1,
      pm_100k_gnd = 2'h2,
      pm_high_z = 2'h3
   } power_mode_t;
   typedef enum {fs_idle, fs_shift, fs_done} frame_state_t;
endpackage

// file: rtl/dac_serial_load_power_control.sv
// serial-load front end: frame capture, code register, power-mode control
// assumes host drives select, serial clock and data asynchronously, at most
// 50 MHz serial clock, so each serial half period spans at least one clk
`timescale 1ns/1ns
module dac_serial_load_power_control #(
   parameter bit wide_variant = 1'b0,
   parameter int unsigned wake_count = dac_load_pkg::wake_cycles
) (
   // system
   input wire logic clk,
   input wire logic rst,
   // serial link pins
   input wire logic frame_sel_n,
   input wire logic serial_clk,
   input wire logic serial_din,
   // converter core
   output logic [15:0] dac_code,
   output dac_load_pkg::power_mode_t power_mode,
   output logic amp_enable,
   output logic term_1k_en,
   output logic term_100k_en,
   output logic output_valid,
   output logic exec_pulse
);
   import dac_load_pkg::*;

   localparam int unsigned code_w = wide_variant ? wide_code_w : narrow_code_w;
   localparam int unsigned exec_edge =
      wide_variant ? wide_exec_edge : narrow_exec_edge;
   localparam int unsigned sh_w = exec_edge;

   // two-stage synchronisers; stage one feeds stage two only
   logic [2:0] sync1_r, sync2_r;
   logic sclk_d_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_r <= 3'h7;
         sync2_r <= 3'h7;
         sclk_d_r <= 1'b1;
      end else begin
         sync1_r <= {frame_sel_n, serial_clk, serial_din};
         sync2_r <= sync1_r;
         sclk_d_r <= sync2_r[1];
      end
   end
   logic sel_n_s, sclk_s, din_s, sclk_fall;
   assign sel_n_s = sync2_r[2];
   assign sclk_s = sync2_r[1];
   assign din_s = sync2_r[0];
   // data is sampled at the synchronised clock fall, taken from the same sync stage as the clock
   assign sclk_fall = sclk_d_r & ~sclk_s;

   // frame capture
   frame_state_t state_r, state_nxt;
   logic [sh_w-1:0] shift_r, shift_nxt;
   logic [4:0] count_r, count_nxt;
   logic sel_prev_r, sel_prev_nxt;
   logic exec_nxt;
   always_comb begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      count_nxt = count_r;
      sel_prev_nxt = sel_n_s;
      exec_nxt = 1'b0;
      case (state_r)
         fs_idle: begin
            if (sel_prev_r && !sel_n_s) begin
               state_nxt = fs_shift;
               shift_nxt = '0;
               count_nxt = 5'h0;
            end
         end
         fs_shift: begin
            if (sel_n_s) begin
               // early rise drops partial frame
               state_nxt = fs_idle;
               shift_nxt = '0;
               count_nxt = 5'h0;
            end else if (sclk_fall) begin
               // msb first: shift in at the bottom
               shift_nxt = {shift_r[sh_w-2:0], din_s};
               count_nxt = count_r + 5'h1;
               if (count_r == 5'(exec_edge - 1)) begin
                  state_nxt = fs_done;
                  exec_nxt = 1'b1;
               end
            end
         end
         fs_done: begin
            // remaining edges, incl. wide don't-care bits, ignored
            if (sel_n_s) begin
               state_nxt = fs_idle;
            end
         end
         default: state_nxt = fs_idle;
      endcase
   end
   logic exec_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= fs_idle;
         shift_r <= '0;
         count_r <= 5'h0;
         sel_prev_r <= 1'b1;
         exec_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         count_r <= count_nxt;
         sel_prev_r <= sel_prev_nxt;
         exec_r <= exec_nxt;
      end
   end

   // code and mode registers, loaded from the full shift word
   logic [15:0] code_r, code_nxt;
   power_mode_t mode_r, mode_nxt;
   logic [sh_w-1:0] word;
   assign word = shift_r;
   always_comb begin
      code_nxt = code_r;
      mode_nxt = mode_r;
      if (exec_r) begin
         // frame layout: mode hi, mode lo, code msb..lsb
         mode_nxt = power_mode_t'({word[sh_w-1-mode_lo_pos],
                                   word[sh_w-1-mode_hi_pos]});
         // code kept across power-down, reloaded only by a frame
         code_nxt = 16'(word[code_w-1:0]);
      end
   end

   // wake timer after leaving power-down; long count is a parameter
   logic [$clog2(wake_count+1)-1:0] wake_r, wake_nxt;
   logic valid_r, valid_nxt;
   always_comb begin
      wake_nxt = wake_r;
      valid_nxt = valid_r;
      // follow the next mode so valid drops with the mode, not a cycle late
      if (mode_nxt != pm_normal) begin
         valid_nxt = 1'b0;
         wake_nxt = '0;
      end else if (!valid_r) begin
         if (wake_r == $bits(wake_r)'(wake_count - 1)) begin
            valid_nxt = 1'b1;
         end else begin
            wake_nxt = wake_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         code_r <= 16'(code_reset);
         mode_r <= power_mode_t'(mode_reset);
         wake_r <= '0;
         valid_r <= 1'b1;
      end else begin
         code_r <= code_nxt;
         mode_r <= mode_nxt;
         wake_r <= wake_nxt;
         valid_r <= valid_nxt;
      end
   end

   // output stage steering
   assign dac_code = code_r;
   assign power_mode = mode_r;
   assign amp_enable = (mode_r == pm_normal);
   assign term_1k_en = (mode_r == pm_1k_gnd);
   assign term_100k_en = (mode_r == pm_100k_gnd);
   assign output_valid = valid_r;
   assign exec_pulse = exec_r;

   // checks
   sequence early_rise_s;
      state_r == fs_shift && sel_n_s;
   endsequence
   sequence exec_s;
      exec_r;
   endsequence
   sequence bit_taken_s;
      state_r == fs_shift && !sel_n_s && sclk_fall;
   endsequence
   sequence bit_wait_s;
      state_r == fs_shift && !sel_n_s && !sclk_fall;
   endsequence
   sequence frame_open_s;
      state_r == fs_idle && state_nxt == fs_shift;
   endsequence

   // frame capture steps
   sync_chain_a: assert property (@(posedge clk) disable iff (rst)
      sync2_r == $past(sync1_r))
      else $error("synchroniser stage skipped");
   sclk_edge_a: assert property (@(posedge clk) disable iff (rst)
      sclk_fall |-> $past(sync2_r[1]) && !sync2_r[1])
      else $error("serial edge without a falling clock");
   start_clear_a: assert property (@(posedge clk) disable iff (rst)
      frame_open_s |=> count_r == 5'h0 && shift_r == '0)
      else $error("new frame not cleared");
   shift_step_a: assert property (@(posedge clk) disable iff (rst)
      bit_taken_s |=> count_r == $past(count_r) + 5'h1)
      else $error("bit count not advanced");
   shift_data_a: assert property (@(posedge clk) disable iff (rst)
      bit_taken_s |=> shift_r[0] == $past(din_s))
      else $error("data bit not shifted in");
   no_edge_hold_a: assert property (@(posedge clk) disable iff (rst)
      bit_wait_s |=> $stable(shift_r) && $stable(count_r))
      else $error("shift register moved without an edge");
   count_max_a: assert property (@(posedge clk) disable iff (rst)
      state_r == fs_shift |-> count_r < 5'(exec_edge))
      else $error("bit count beyond executing edge");
   exec_shift_a: assert property (@(posedge clk) disable iff (rst)
      exec_nxt |-> state_r == fs_shift)
      else $error("update outside a frame");
   exec_once_a: assert property (@(posedge clk) disable iff (rst)
      exec_s |=> !exec_r)
      else $error("update pulse longer than one cycle");
   early_noexec_a: assert property (@(posedge clk) disable iff (rst)
      early_rise_s |-> !exec_nxt)
      else $error("aborted frame executed");
   idle_wait_a: assert property (@(posedge clk) disable iff (rst)
      state_r == fs_idle && !sel_prev_r |=> state_r == fs_idle)
      else $error("frame opened without select edge");
   done_hold_a: assert property (@(posedge clk) disable iff (rst)
      state_r == fs_done && !sel_n_s |=> state_r == fs_done)
      else $error("executed frame left while selected");
   done_exit_a: assert property (@(posedge clk) disable iff (rst)
      state_r == fs_done && sel_n_s |=> state_r == fs_idle)
      else $error("frame not closed on select rise");

   // register and output stage
   mode_load_a: assert property (@(posedge clk) disable iff (rst)
      exec_s |=> mode_r == power_mode_t'({$past(shift_r[sh_w-1]),
                                          $past(shift_r[sh_w-2])}))
      else $error("mode not taken from the leading bits");
   code_top_a: assert property (@(posedge clk) disable iff (rst)
      (code_r >> code_w) == 16'h0000)
      else $error("code wider than the variant");
   pd_keep_a: assert property (@(posedge clk) disable iff (rst)
      mode_r != pm_normal && !exec_r |=> $stable(code_r))
      else $error("code lost in power-down");
   amp_normal_a: assert property (@(posedge clk) disable iff (rst)
      mode_r == pm_normal |-> amp_enable && !term_1k_en && !term_100k_en)
      else $error("normal mode output stage wrong");
   term_1k_a: assert property (@(posedge clk) disable iff (rst)
      mode_r == pm_1k_gnd |-> term_1k_en && !term_100k_en && !amp_enable)
      else $error("1k termination not selected");
   term_100k_a: assert property (@(posedge clk) disable iff (rst)
      mode_r == pm_100k_gnd |-> term_100k_en && !term_1k_en && !amp_enable)
      else $error("100k termination not selected");

   // wake timer
   wake_clear_a: assert property (@(posedge clk) disable iff (rst)
      mode_r != pm_normal |-> wake_r == '0)
      else $error("wake timer runs in power-down");
   wake_step_a: assert property (@(posedge clk) disable iff (rst)
      mode_r == pm_normal && !valid_r && !exec_r &&
      wake_r != $bits(wake_r)'(wake_count - 1)
      |=> wake_r == $past(wake_r) + 1'b1)
      else $error("wake timer stalled");
   valid_hold_a: assert property (@(posedge clk) disable iff (rst)
      valid_r && mode_r == pm_normal && !exec_r |=> valid_r)
      else $error("valid dropped in normal mode");
   reset_state_a: assert property (@(posedge clk)
      $fell(rst) |-> state_r == fs_idle && valid_r && !exec_r)
      else $error("frame logic not idle after reset");

   reset_zero_a: assert property (@(posedge clk)
      $fell(rst) |-> code_r == 16'h0000 && mode_r == pm_normal)
      else $error("code or mode not cleared after reset");
   exec_count_a: assert property (@(posedge clk) disable iff (rst)
      exec_nxt |-> count_r == 5'(exec_edge - 1) && sclk_fall)
      else $error("update not on the executing edge");
   abort_nochange_a: assert property (@(posedge clk) disable iff (rst)
      early_rise_s |=> !exec_r ##1 $stable(code_r))
      else $error("aborted frame changed the code");
   abort_clear_a: assert property (@(posedge clk) disable iff (rst)
      early_rise_s |=> state_r == fs_idle && shift_r == '0)
      else $error("shift register not reset on early rise");
   ignore_after_a: assert property (@(posedge clk) disable iff (rst)
      state_r == fs_done |-> !exec_nxt)
      else $error("second execution within one frame");
   hold_code_a: assert property (@(posedge clk) disable iff (rst)
      !exec_r |=> $stable(code_r) && $stable(mode_r))
      else $error("code or mode changed without a frame");
   load_code_a: assert property (@(posedge clk) disable iff (rst)
      exec_s |=> code_r == 16'($past(shift_r[code_w-1:0])))
      else $error("code not loaded from frame");
   output_sw_a: assert property (@(posedge clk) disable iff (rst)
      mode_r != pm_normal |-> !amp_enable && !valid_r)
      else $error("amplifier active in power-down");
   term_map_a: assert property (@(posedge clk) disable iff (rst)
      mode_r == pm_high_z |-> !term_1k_en && !term_100k_en)
      else $error("termination enabled in high-z mode");
   wake_delay_a: assert property (@(posedge clk) disable iff (rst)
      $rose(valid_r) |-> wake_r == $bits(wake_r)'(wake_count - 1))
      else $error("output valid before wake delay");
   start_edge_a: assert property (@(posedge clk) disable iff (rst)
      state_r == fs_idle && state_nxt == fs_shift |-> $fell(sel_n_s))
      else $error("frame started without select falling");
endmodule
